// file: include/wake_pkg.sv
package wake_pkg;

  // ==========================================================
  // widths
  localparam int PORT_W = 12;
  localparam int CNT_W = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 32;
  localparam int DEB_W = 6;
  localparam int TICK_W = 17;

  // ==========================================================
  // register addresses
  localparam logic [ADDR_W-1:0] WAKE_CONTROL_ADDR = 32'h5000_0100;
  localparam logic [ADDR_W-1:0] WAKE_THRESHOLD_ADDR = 32'h5000_0102;
  localparam logic [ADDR_W-1:0] WAKE_IRQ_FLAGS_ADDR = 32'h5000_0104;
  localparam logic [ADDR_W-1:0] WAKE_EVENT_COUNTS_ADDR = 32'h5000_0106;
  localparam logic [ADDR_W-1:0] FIRST_SRC_MASK_ADDR = 32'h5000_0108;
  localparam logic [ADDR_W-1:0] SECOND_SRC_MASK_ADDR = 32'h5000_010a;
  localparam logic [ADDR_W-1:0] FIRST_POLARITY_ADDR = 32'h5000_010c;
  localparam logic [ADDR_W-1:0] SECOND_POLARITY_ADDR = 32'h5000_010e;
  localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 32'h5000_0110;
  localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 32'h5000_0112;

  // ==========================================================
  // field positions
  localparam int FINE_SEL_BIT = 9;
  localparam int IRQ2_EN_BIT = 8;
  localparam int IRQ1_EN_BIT = 7;
  localparam int KEY_HIT_BIT = 6;
  localparam int CTRL_W = 10;
  localparam int CLR2_BIT = 3;
  localparam int CLR1_BIT = 2;
  localparam int PEND2_BIT = 1;
  localparam int PEND1_BIT = 0;
  localparam int CNT2_LSB = 8;
  localparam int EVT1_BIT = 0;
  localparam int EVT2_BIT = 1;
  localparam int EVT_W = 2;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CNT = 8'h00;
  localparam logic [PORT_W-1:0] RST_PORT = 12'h000;
  localparam logic [CTRL_W-1:0] RST_CTRL = 10'h000;
  localparam logic [EVT_W-1:0] RST_EVT = 2'h0;
  localparam logic [DEB_W-1:0] RST_DEB = 6'h00;
  localparam logic [DEB_W-1:0] DEB_OFF = 6'h00;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int COARSE_UNIT_NS = 1000000;
  localparam int FINE_UNIT_NS = 125000;
  localparam int COARSE_CYCLES = COARSE_UNIT_NS / CLK_PERIOD_NS;
  localparam int FINE_CYCLES = FINE_UNIT_NS / CLK_PERIOD_NS;

  // ==========================================================
  // debounce channel states
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_SETTLE,
    CH_HELD
  } chan_state_t;

endpackage : wake_pkg

// file: include/wake_chan_if.sv
`timescale 1ns/1ps
// ==========================================================
// one counting channel: setup from top, event back
interface wake_chan_if
  import wake_pkg::*;
();
  logic [PORT_W-1:0] pins; // raw port inputs
  logic [PORT_W-1:0] sel; // source mask
  logic [PORT_W-1:0] pol; // 1 = active low
  logic key_hit; // emulated key level
  logic [DEB_W-1:0] deb_len; // debounce units
  logic tick; // debounce unit pulse
  logic event_p; // one-cycle counted event

  modport ctl (output pins, sel, pol, key_hit, deb_len, tick,
               input event_p);
  modport chan (input pins, sel, pol, key_hit, deb_len, tick,
                output event_p);
endinterface : wake_chan_if

// file: core/debounce_tick_gen.sv
`timescale 1ns/1ps
// ==========================================================
// debounce unit tick, coarse or fine period
module debounce_tick_gen
  import wake_pkg::*;
#(
  parameter int COARSE = COARSE_CYCLES,
  parameter int FINE = FINE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic fine_sel,
  output logic tick
);
  localparam logic [TICK_W-1:0] COARSE_LIM = TICK_W'(COARSE - 1);
  localparam logic [TICK_W-1:0] FINE_LIM = TICK_W'(FINE - 1);
  localparam logic [TICK_W-1:0] ZERO = '0;

  logic [TICK_W-1:0] cnt_r; // cycles within unit
  logic sel_r; // last seen unit select
  logic [TICK_W-1:0] lim; // terminal count

  assign lim = fine_sel ? FINE_LIM : COARSE_LIM;

  // restart on a select change so no unit runs long
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= ZERO;
      sel_r <= 1'b0;
      tick <= 1'b0;
    end else begin
      sel_r <= fine_sel;
      if (sel_r != fine_sel || cnt_r == lim) begin
        cnt_r <= ZERO;
        tick <= (cnt_r == lim);
      end else begin
        cnt_r <= cnt_r + 1'b1;
        tick <= 1'b0;
      end
    end
  end
endmodule : debounce_tick_gen

// file: core/event_channel.sv
`timescale 1ns/1ps
// ==========================================================
// select, polarity and debounce for one counter
module event_channel
  import wake_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  wake_chan_if.chan ch
);
  chan_state_t state_r; // debounce state
  logic [DEB_W-1:0] ticks_r; // ticks seen while settling
  logic active; // any enabled source at active level

  // masked pins flipped by polarity, plus the emulated key
  assign active = (|(ch.sel & (ch.pins ^ ch.pol))) | ch.key_hit;

  // the first tick is partial, so wait one extra tick:
  // the level is then stable for at least the full length
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= CH_IDLE;
      ticks_r <= RST_DEB;
      ch.event_p <= 1'b0;
    end else begin
      ch.event_p <= 1'b0;
      unique case (state_r)
        CH_IDLE: begin
          ticks_r <= RST_DEB;
          if (active) begin
            if (ch.deb_len == DEB_OFF) begin
              ch.event_p <= 1'b1;
              state_r <= CH_HELD;
            end else begin
              state_r <= CH_SETTLE;
            end
          end
        end
        CH_SETTLE: begin
          if (!active) begin
            state_r <= CH_IDLE; // glitch dropped
          end else if (ch.tick) begin
            if (ticks_r == ch.deb_len) begin
              ch.event_p <= 1'b1;
              state_r <= CH_HELD;
            end else begin
              ticks_r <= ticks_r + 1'b1;
            end
          end
        end
        CH_HELD: begin
          // re-arm only after release, so a held key counts once
          if (!active) begin
            state_r <= CH_IDLE;
          end
        end
      endcase
    end
  end
endmodule : event_channel

// file: core/wake_counter.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// ==========================================================
// wake-up event counter: two channels, registers, interrupt
module wake_counter
  import wake_pkg::*;
#(
  parameter int COARSE_TICK_CYCLES = COARSE_CYCLES,
  parameter int FINE_TICK_CYCLES = FINE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [PORT_W-1:0] first_port,
  input wire logic [PORT_W-1:0] second_port,
  output logic irq,
  output logic first_wake_pending,
  output logic second_wake_pending
);

  // ==========================================================
  // helpers

  // threshold holds events minus one, so the hit is the
  // event that arrives while the count equals the threshold
  function automatic logic thresh_hit(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] cmp
  );
    thresh_hit = (cnt == cmp);
  endfunction : thresh_hit

  // widen a narrow field into a read word, upper bits zero
  function automatic logic [DATA_W-1:0] pad_port(
    input logic [PORT_W-1:0] v
  );
    pad_port = {{(DATA_W - PORT_W){1'b0}}, v};
  endfunction : pad_port

  // ==========================================================
  // software-visible state

  logic [CTRL_W-1:0] ctrl_r; // wake_control fields
  logic [CNT_W-1:0] thresh_r; // wake_threshold
  logic [PORT_W-1:0] first_sel_r; // first_source_mask
  logic [PORT_W-1:0] second_sel_r; // second_source_mask
  logic [PORT_W-1:0] first_pol_r; // first_edge_polarity
  logic [PORT_W-1:0] second_pol_r; // second_edge_polarity
  logic [CNT_W-1:0] first_cnt_r; // first event count
  logic [CNT_W-1:0] second_cnt_r; // second_event_count
  logic [EVT_W-1:0] evt_r; // sticky event status
  logic [EVT_W-1:0] evt_nxt; // next event status
  logic [EVT_W-1:0] evt_mask_r; // event interrupt mask

  // ==========================================================
  // decoded control fields

  logic fine_debounce_tick_sel; // 125 us unit
  logic first_counter_irq_en; // first interrupt enable
  logic second_counter_irq_en; // second interrupt enable
  logic emulated_key_hit; // software key level
  logic [DEB_W-1:0] debounce_length; // units, 0 = off

  assign fine_debounce_tick_sel = ctrl_r[FINE_SEL_BIT];
  assign second_counter_irq_en = ctrl_r[IRQ2_EN_BIT];
  assign first_counter_irq_en = ctrl_r[IRQ1_EN_BIT];
  assign emulated_key_hit = ctrl_r[KEY_HIT_BIT];
  assign debounce_length = ctrl_r[DEB_W-1:0];

  // ==========================================================
  // bus decode

  logic wr_ctrl; // write to wake_control
  logic wr_thresh; // write to wake_threshold
  logic wr_flags; // write to wake_irq_flags
  logic wr_fsel; // write to first mask
  logic wr_ssel; // write to second mask
  logic wr_fpol; // write to first polarity
  logic wr_spol; // write to second polarity
  logic wr_emask; // write to event mask
  logic rd_evt; // read of event status

  assign wr_ctrl = wr && (addr == WAKE_CONTROL_ADDR);
  assign wr_thresh = wr && (addr == WAKE_THRESHOLD_ADDR);
  assign wr_flags = wr && (addr == WAKE_IRQ_FLAGS_ADDR);
  assign wr_fsel = wr && (addr == FIRST_SRC_MASK_ADDR);
  assign wr_ssel = wr && (addr == SECOND_SRC_MASK_ADDR);
  assign wr_fpol = wr && (addr == FIRST_POLARITY_ADDR);
  assign wr_spol = wr && (addr == SECOND_POLARITY_ADDR);
  assign wr_emask = wr && (addr == EVENT_MASK_ADDR);
  assign rd_evt = rd && (addr == EVENT_STATUS_ADDR);

  // write-one strobes of the flag register
  logic first_counter_clear; // clears first count
  logic second_counter_clear; // clears second count
  logic first_pend_clr; // clears first pending
  logic second_pend_clr; // clears second pending

  assign first_counter_clear = wr_flags && wdata[CLR1_BIT];
  assign second_counter_clear = wr_flags && wdata[CLR2_BIT];
  assign first_pend_clr = wr_flags && wdata[PEND1_BIT];
  assign second_pend_clr = wr_flags && wdata[PEND2_BIT];

  // ==========================================================
  // debounce tick and the two channels

  logic tick; // shared debounce unit pulse

  debounce_tick_gen #(
    .COARSE(COARSE_TICK_CYCLES),
    .FINE(FINE_TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .fine_sel(fine_debounce_tick_sel),
    .tick(tick)
  );

  wake_chan_if first_ch ();
  wake_chan_if second_ch ();

  // both channels share the key level and debounce setup
  assign first_ch.pins = first_port;
  assign first_ch.sel = first_sel_r;
  assign first_ch.pol = first_pol_r;
  assign first_ch.key_hit = emulated_key_hit;
  assign first_ch.deb_len = debounce_length;
  assign first_ch.tick = tick;

  assign second_ch.pins = second_port;
  assign second_ch.sel = second_sel_r;
  assign second_ch.pol = second_pol_r;
  assign second_ch.key_hit = emulated_key_hit;
  assign second_ch.deb_len = debounce_length;
  assign second_ch.tick = tick;

  event_channel u_first (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ch(first_ch.chan)
  );

  event_channel u_second (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ch(second_ch.chan)
  );

  // ==========================================================
  // threshold hits

  logic first_hit; // first counter reaches threshold
  logic second_hit; // second counter reaches threshold

  // a clear in the same cycle wins and drops the event
  assign first_hit = first_ch.event_p && !first_counter_clear
                     && thresh_hit(first_cnt_r, thresh_r);
  assign second_hit = second_ch.event_p && !second_counter_clear
                      && thresh_hit(second_cnt_r, thresh_r);

  // ==========================================================
  // control registers

  // key-hit bit stays set until software writes it back to 0
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= RST_CTRL;
      thresh_r <= RST_CNT;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata[CTRL_W-1:0];
      end
      if (wr_thresh) begin
        thresh_r <= wdata[CNT_W-1:0];
      end
    end
  end

  // source masks and polarities
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_sel_r <= RST_PORT;
      second_sel_r <= RST_PORT;
      first_pol_r <= RST_PORT;
      second_pol_r <= RST_PORT;
    end else begin
      if (wr_fsel) begin
        first_sel_r <= wdata[PORT_W-1:0];
      end
      if (wr_ssel) begin
        second_sel_r <= wdata[PORT_W-1:0];
      end
      if (wr_fpol) begin
        first_pol_r <= wdata[PORT_W-1:0];
      end
      if (wr_spol) begin
        second_pol_r <= wdata[PORT_W-1:0];
      end
    end
  end

  // ==========================================================
  // event counters, wrap at full scale

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_cnt_r <= RST_CNT;
    end else if (first_counter_clear) begin
      first_cnt_r <= RST_CNT;
    end else if (first_ch.event_p) begin
      first_cnt_r <= first_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second_cnt_r <= RST_CNT;
    end else if (second_counter_clear) begin
      second_cnt_r <= RST_CNT;
    end else if (second_ch.event_p) begin
      second_cnt_r <= second_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // wake pending flags: set wins over a write-one clear

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_wake_pending <= 1'b0;
    end else if (first_hit && first_counter_irq_en) begin
      first_wake_pending <= 1'b1;
    end else if (first_pend_clr) begin
      first_wake_pending <= 1'b0;
    end
    // further events never clear it
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second_wake_pending <= 1'b0;
    end else if (second_hit && second_counter_irq_en) begin
      second_wake_pending <= 1'b1;
    end else if (second_pend_clr) begin
      second_wake_pending <= 1'b0;
    end
  end

  // ==========================================================
  // sticky event status, mask and interrupt line

  logic [EVT_W-1:0] evt_set; // new wake interrupts this cycle

  always_comb begin
    evt_set = RST_EVT;
    evt_set[EVT1_BIT] = first_hit && first_counter_irq_en;
    evt_set[EVT2_BIT] = second_hit && second_counter_irq_en;
    // read clears, but an event in the same cycle survives
    evt_nxt = (rd_evt ? RST_EVT : evt_r) | evt_set;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evt_r <= RST_EVT;
      evt_mask_r <= RST_EVT;
      irq <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      if (wr_emask) begin
        evt_mask_r <= wdata[EVT_W-1:0];
      end
      irq <= |(evt_nxt & evt_mask_r);
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe, else zero

  logic [DATA_W-1:0] rdata_nxt; // selected read word

  always_comb begin
    rdata_nxt = RST_DATA;
    if (rd) begin
      unique case (addr)
        WAKE_CONTROL_ADDR: begin
          rdata_nxt[CTRL_W-1:0] = ctrl_r;
        end
        WAKE_THRESHOLD_ADDR: begin
          rdata_nxt[CNT_W-1:0] = thresh_r;
        end
        WAKE_IRQ_FLAGS_ADDR: begin
          // counter clear bits always read zero
          rdata_nxt[PEND1_BIT] = first_wake_pending;
          rdata_nxt[PEND2_BIT] = second_wake_pending;
        end
        WAKE_EVENT_COUNTS_ADDR: begin
          rdata_nxt = {second_cnt_r, first_cnt_r};
        end
        FIRST_SRC_MASK_ADDR: begin
          rdata_nxt = pad_port(first_sel_r);
        end
        SECOND_SRC_MASK_ADDR: begin
          rdata_nxt = pad_port(second_sel_r);
        end
        FIRST_POLARITY_ADDR: begin
          rdata_nxt = pad_port(first_pol_r);
        end
        SECOND_POLARITY_ADDR: begin
          rdata_nxt = pad_port(second_pol_r);
        end
        EVENT_STATUS_ADDR: begin
          rdata_nxt[EVT_W-1:0] = evt_r;
        end
        EVENT_MASK_ADDR: begin
          rdata_nxt[EVT_W-1:0] = evt_mask_r;
        end
        default: begin
          rdata_nxt = RST_DATA; // unmapped reads zero
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= RST_DATA;
    end else begin
      rdata <= rdata_nxt;
    end
  end

endmodule : wake_counter

// file: verif/wake_counter_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checker for the wake-up counter
module wake_counter_sva
  import wake_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [PORT_W-1:0] first_port,
  input wire logic [PORT_W-1:0] second_port,
  input wire logic irq,
  input wire logic first_wake_pending,
  input wire logic second_wake_pending
);
  logic [CTRL_W-1:0] ctrl_r; // shadow of the control register
  logic fw; // write to the flag register

  assign fw = wr && addr == WAKE_IRQ_FLAGS_ADDR;

  // ==========================================================
  // shadow control: enable bits gate the pending flags
  // the design sees the enable before the edge, hence $past
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= RST_CTRL;
    end else if (wr && addr == WAKE_CONTROL_ADDR) begin
      ctrl_r <= wdata[CTRL_W-1:0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // sequences
  sequence s_flag_rd;
    rd && addr == WAKE_IRQ_FLAGS_ADDR;
  endsequence
  // counter clear wins over the event, so no hit can land
  sequence s_kill1;
    fw && wdata[CLR1_BIT] && wdata[PEND1_BIT];
  endsequence
  sequence s_kill2;
    fw && wdata[CLR2_BIT] && wdata[PEND2_BIT];
  endsequence

  // ==========================================================
  // assertions
  a_pend1_hold: assert property (
    first_wake_pending && !(fw && wdata[PEND1_BIT]) |=> first_wake_pending)
    else $error("first pending dropped without clear");
  a_pend2_hold: assert property (
    second_wake_pending && !(fw && wdata[PEND2_BIT]) |=> second_wake_pending)
    else $error("second pending dropped without clear");
  a_pend1_gate: assert property (
    $rose(first_wake_pending) |-> $past(ctrl_r[IRQ1_EN_BIT]))
    else $error("first pending set while disabled");
  a_pend2_gate: assert property (
    $rose(second_wake_pending) |-> $past(ctrl_r[IRQ2_EN_BIT]))
    else $error("second pending set while disabled");
  a_clr1_wins: assert property (s_kill1 |=> !first_wake_pending)
    else $error("first pending survived clear");
  a_clr2_wins: assert property (s_kill2 |=> !second_wake_pending)
    else $error("second pending survived clear");
  a_flag_read: assert property (s_flag_rd |=> rdata ==
    {14'h0000, $past(second_wake_pending), $past(first_wake_pending)})
    else $error("flag read mismatch");
  a_rdata_quiet: assert property (!rd |=> rdata == RST_DATA)
    else $error("read data outside read slot");
endmodule : wake_counter_sva

bind wake_counter wake_counter_sva u_wake_sva (
  .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .first_port(first_port),
  .second_port(second_port), .irq(irq),
  .first_wake_pending(first_wake_pending),
  .second_wake_pending(second_wake_pending)
);

// file: verif/key_pad_model.sv
`timescale 1ns/1ps
// ==========================================================
// keys on both ports; every press is released again
module key_pad_model
  import wake_pkg::*;
(
  input wire logic ref_clk,
  output logic [PORT_W-1:0] first_port,
  output logic [PORT_W-1:0] second_port
);
  initial begin
    first_port = RST_PORT;
    second_port = RST_PORT;
  end

  // invert the pins in m on one port
  task automatic flip(input int p, input logic [PORT_W-1:0] m);
    if (p == 0)
      first_port <= first_port ^ m;
    else
      second_port <= second_port ^ m;
  endtask : flip

  // set the idle level of a whole port
  task automatic drive(input int p, input logic [PORT_W-1:0] v);
    @(posedge ref_clk);
    if (p == 0)
      first_port <= v;
    else
      second_port <= v;
  endtask : drive

  // hold pin b away from idle for n cycles, then let go
  task automatic press(input int p, input int b, input int n);
    logic [PORT_W-1:0] m;
    m = RST_PORT;
    m[b] = 1'b1;
    @(posedge ref_clk);
    flip(p, m);
    repeat (n) @(posedge ref_clk);
    flip(p, m); // release before the next press
  endtask : press
endmodule : key_pad_model

// file: verif/tb.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the wake-up counter
module tb
  import wake_pkg::*;
;
  localparam int COARSE_T = 20; // shortened debounce units
  localparam int FINE_T = 5;
  logic ref_clk, rstn, wr, rd, irq;
  logic first_wake_pending, second_wake_pending;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [PORT_W-1:0] first_port, second_port;
  int miscompares, tests_run, i, p, pol, b, t, u;

  wake_counter #(.COARSE_TICK_CYCLES(COARSE_T),
    .FINE_TICK_CYCLES(FINE_T)) i_wake_counter (
    .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .first_port(first_port),
    .second_port(second_port), .irq(irq),
    .first_wake_pending(first_wake_pending),
    .second_wake_pending(second_wake_pending));
  key_pad_model u_keys (.ref_clk(ref_clk), .first_port(first_port),
    .second_port(second_port));

  always #5 ref_clk = ~ref_clk;

  // ==========================================================
  // compares and verdict
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: read %h expected %h", $time, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: flag %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic end_of_test;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // bus cycles; strobes last one cycle
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk16(rdata, e); // data stands in the cycle after the strobe
  endtask : rd_chk
  // emulated key: set then drop the bit, on top of control c
  task automatic key_hit(input logic [15:0] c);
    wr_reg(WAKE_CONTROL_ADDR, c | 16'h0040);
    wr_reg(WAKE_CONTROL_ADDR, c);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : key_hit
  // expected count register: second count high, first low
  function automatic logic [15:0] cnt_word(input int c2, input int c1);
    return {c2[7:0], c1[7:0]};
  endfunction : cnt_word

  // watchdog: the run takes about 500 cycles; allow 20k
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    {wr, rd, addr, wdata} = '0;
    miscompares = 0;
    tests_run = 0;
    t = $urandom(32'hd2b1);
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (i = 0; i < 8; i++)
      rd_chk(WAKE_CONTROL_ADDR + 32'(2 * i), RST_DATA);
    rd_chk(32'h5000_0114, RST_DATA);
    // random register contents, reserved bits read zero
    t = $urandom;
    wr_reg(WAKE_CONTROL_ADDR, 16'(t) & 16'hffbf);
    rd_chk(WAKE_CONTROL_ADDR, 16'(t) & 16'h03bf);
    wr_reg(WAKE_THRESHOLD_ADDR, 16'(t));
    rd_chk(WAKE_THRESHOLD_ADDR, 16'(t) & 16'h00ff);
    for (i = 4; i < 8; i++) begin
      wr_reg(WAKE_CONTROL_ADDR + 32'(2 * i), 16'(t));
      rd_chk(WAKE_CONTROL_ADDR + 32'(2 * i), 16'(t) & 16'h0fff);
    end
    wr_reg(WAKE_EVENT_COUNTS_ADDR, 16'hffff);
    // a second reset leaves everything clean again
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(WAKE_EVENT_COUNTS_ADDR, RST_DATA);
    // each enable pattern, threshold zero: one hit is enough
    for (i = 0; i < 4; i++) begin
      wr_reg(WAKE_IRQ_FLAGS_ADDR, 16'h000f);
      key_hit(16'(i) << IRQ1_EN_BIT);
      rd_chk(WAKE_EVENT_COUNTS_ADDR, cnt_word(1, 1));
      chk1(first_wake_pending, i[0]);
      chk1(second_wake_pending, i[1]);
      rd_chk(WAKE_IRQ_FLAGS_ADDR, 16'(i));
    end
    key_hit(16'h0180);
    chk1(first_wake_pending, 1'b1);
    rd_chk(WAKE_EVENT_COUNTS_ADDR, cnt_word(2, 2));
    wr_reg(WAKE_IRQ_FLAGS_ADDR, 16'h0001);
    rd_chk(WAKE_IRQ_FLAGS_ADDR, 16'h0002);
    wr_reg(WAKE_IRQ_FLAGS_ADDR, 16'h0004);
    rd_chk(WAKE_EVENT_COUNTS_ADDR, cnt_word(2, 0));
    wr_reg(WAKE_IRQ_FLAGS_ADDR, 16'h000a);
    rd_chk(WAKE_IRQ_FLAGS_ADDR, RST_DATA);
    rd_chk(WAKE_EVENT_COUNTS_ADDR, RST_DATA);
    chk1(irq, 1'b0); // status set but masked
    // unmask the second status bit: the line must rise
    wr_reg(EVENT_MASK_ADDR, 16'h0002);
    // threshold t hits on event t+1; irq unmasked for first
    t = 1 + $urandom % 4;
    wr_reg(WAKE_THRESHOLD_ADDR, 16'(t));
    #1;
    chk1(irq, 1'b1);
    rd_chk(EVENT_STATUS_ADDR, 16'h0003);
    wr_reg(EVENT_MASK_ADDR, 16'h0001);
    for (i = 0; i <= t; i++) begin
      chk1(irq, 1'b0);
      key_hit(16'h0080);
      chk1(first_wake_pending, 1'(i == t));
    end
    chk1(second_wake_pending, 1'b0);
    chk1(irq, 1'b1);
    rd_chk(EVENT_STATUS_ADDR, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1;
    chk1(irq, 1'b0);
    // pins: random bit, both ports, both polarities
    for (p = 0; p < 2; p++) begin
      for (pol = 0; pol < 2; pol++) begin
        b = $urandom % PORT_W;
        u_keys.drive(p, pol ? (12'h001 << b) : RST_PORT);
        wr_reg(FIRST_POLARITY_ADDR + 32'(2 * p), 16'(pol) << b);
        wr_reg(FIRST_SRC_MASK_ADDR + 32'(2 * p), 16'h0001 << b);
        wr_reg(WAKE_IRQ_FLAGS_ADDR, 16'h000c);
        u_keys.press(p, (b + 1) % PORT_W, 4);
        u_keys.press(1 - p, b, 4);
        u_keys.press(p, b, 4);
        rd_chk(WAKE_EVENT_COUNTS_ADDR, cnt_word(p, 1 - p));
        wr_reg(FIRST_SRC_MASK_ADDR + 32'(2 * p), RST_DATA);
        wr_reg(FIRST_POLARITY_ADDR + 32'(2 * p), RST_DATA);
        u_keys.drive(p, RST_PORT);
      end
    end
    // debounce of two units, coarse then fine tick
    wr_reg(FIRST_SRC_MASK_ADDR, 16'h0001);
    for (i = 0; i < 2; i++) begin
      u = i ? FINE_T : COARSE_T;
      wr_reg(WAKE_CONTROL_ADDR, (16'(i) << FINE_SEL_BIT) | 16'h0002);
      wr_reg(WAKE_IRQ_FLAGS_ADDR, 16'h000c);
      u_keys.press(0, 0, 2 * u - 2);
      repeat (u) @(posedge ref_clk);
      rd_chk(WAKE_EVENT_COUNTS_ADDR, cnt_word(0, 0));
      u_keys.press(0, 0, 3 * u + 4);
      repeat (u) @(posedge ref_clk);
      rd_chk(WAKE_EVENT_COUNTS_ADDR, cnt_word(0, 1));
    end
    chk1(irq, 1'b0);
    end_of_test();
  end
endmodule : tb
